// ==== src/adhb_core.sv ====
/*
  alarm on/off delay qualification, alarm setpoint selection and heater
  burnout detection, with an apb register slave.
  assumes all inputs are synchronous to pclk and raw alarm conditions
  come from an external alarm type evaluator.
*/
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/1ns
module adhb_core
  import adhb_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter int MIN_ON_CYCLES = MIN_ON_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // alarms
  input wire logic [N_ALM-1:0] alarm_raw,
  output logic [N_ALM-1:0] alarm_out,
  // setpoint
  input wire logic [SP_W-1:0] ramp_sp,
  input wire logic [SP_W-1:0] final_sp,
  input wire logic sp_ramp_en,
  input wire logic self_tuning,
  output logic [SP_W-1:0] alarm_ref_sp,
  // heater
  input wire logic [N_OUT-1:0] ctrl_out_on,
  input wire logic [N_OUT-1:0] ctrl_out_heat,
  input wire logic [CUR_W-1:0] current_sensor_one,
  input wire logic [CUR_W-1:0] current_sensor_two,
  output logic [N_CT-1:0] heater_open_alarm,
  output logic op_running
);

  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam int OW = $clog2(MIN_ON_CYCLES + 2);

  // ==========================================================
  // apb decode
  logic run_q;
  logic [TYP_W-1:0] typ_q [N_ALM];
  logic sp_sel_q;
  adhb_dly_t dly_q [N_ALM];
  adhb_hb_t hb_q [N_CT];
  logic [CUR_W-1:0] cur_in [N_CT];
  logic [CUR_W-1:0] mon_q [N_CT];
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic setup;
  logic wr;
  logic bad;
  logic cfg_addr;
  logic sw_rst;
  logic err_rst;
  logic [31:0] rd;

  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite & ~pslverr_q;
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;
  assign op_running = run_q;
  assign cur_in[0] = current_sensor_one;
  assign cur_in[1] = current_sensor_two;
  assign sw_rst = wr & (paddr == OFS_CTRL) & pwdata[CTRL_SWRST];
  assign err_rst = wr & (paddr == OFS_CTRL) & pwdata[CTRL_ERRRST];
  assign cfg_addr = (paddr == OFS_ALM_CFG) || (paddr == OFS_DLY0) || (paddr == OFS_DLY1)
    || (paddr == OFS_DLY2) || (paddr == OFS_HYS) || (paddr == OFS_CT_CFG);

  // out-of-range values are refused rather than clipped
  always_comb begin
    bad = 1'b0;
    rd = 32'h0000_0000;
    case (paddr)
      OFS_CTRL: rd[CTRL_RUN] = run_q;
      OFS_ALM_CFG: begin
        rd[11:0] = {typ_q[2], typ_q[1], typ_q[0]};
        rd[ALM_SPSEL] = sp_sel_q;
      end
      OFS_DLY0: rd = {6'h00, dly_q[0].off, 6'h00, dly_q[0].on};
      OFS_DLY1: rd = {6'h00, dly_q[1].off, 6'h00, dly_q[1].on};
      OFS_DLY2: rd = {6'h00, dly_q[2].off, 6'h00, dly_q[2].on};
      OFS_THR: begin
        rd = {5'h00, hb_q[1].thr, 5'h00, hb_q[0].thr};
        bad = pwrite && (pwdata[LO_LSB +: CUR_W] > THR_FORCE_ON
          || pwdata[HI_LSB +: CUR_W] > THR_FORCE_ON);
      end
      OFS_HYS: begin
        rd = {5'h00, hb_q[1].hys, 5'h00, hb_q[0].hys};
        bad = pwrite && (pwdata[LO_LSB +: CUR_W] == 11'h000
          || pwdata[HI_LSB +: CUR_W] == 11'h000
          || pwdata[LO_LSB +: CUR_W] > HYS_MAX || pwdata[HI_LSB +: CUR_W] > HYS_MAX);
      end
      OFS_CT_CFG: begin
        rd[ASG1_LSB +: ASG_W] = hb_q[0].asg;
        rd[ASG2_LSB +: ASG_W] = hb_q[1].asg;
        rd[LATCH_LSB +: 2] = {hb_q[1].latch, hb_q[0].latch};
        // same output for both sensors is legal
        bad = pwrite && (pwdata[ASG1_LSB +: ASG_W] > ASG_MAX
          || pwdata[ASG2_LSB +: ASG_W] > ASG_MAX);
      end
      OFS_STATUS: begin
        rd[N_ALM-1:0] = alarm_out;
        rd[ST_HB_LSB +: N_CT] = heater_open_alarm;
      end
      OFS_MON: begin
        rd = {5'h00, mon_q[1], 5'h00, mon_q[0]};
        bad = pwrite;
      end
      default: bad = 1'b1;
    endcase
    // delays past 999 s are refused like the other ranges
    if (pwrite && (paddr == OFS_DLY0 || paddr == OFS_DLY1 || paddr == OFS_DLY2)
      && (pwdata[LO_LSB +: DLY_W] > DLY_MAX || pwdata[HI_LSB +: DLY_W] > DLY_MAX)) begin
      bad = 1'b1;
    end
    if (pwrite && run_q && cfg_addr) begin
      bad = 1'b1;
    end
  end

  // answer prepared in setup so the access phase needs no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q <= pwrite ? 32'h0000_0000 : rd;
      pslverr_q <= bad;
    end
  end

  // ==========================================================
  // settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 1'b0;
      sp_sel_q <= 1'b0;
      for (int i = 0; i < N_ALM; i++) begin
        typ_q[i] <= '0;
        dly_q[i] <= '0;
      end
      for (int s = 0; s < N_CT; s++) begin
        hb_q[s].thr <= THR_FORCE_OFF;
        hb_q[s].hys <= HYS_RST;
        hb_q[s].latch <= 1'b0;
      end
      hb_q[0].asg <= ASG1_RST;
      hb_q[1].asg <= ASG2_RST;
    end else if (wr) begin
      case (paddr)
        OFS_CTRL: run_q <= pwdata[CTRL_RUN];
        OFS_ALM_CFG: begin
          typ_q[0] <= pwdata[3:0];
          typ_q[1] <= pwdata[7:4];
          typ_q[2] <= pwdata[11:8];
          sp_sel_q <= pwdata[ALM_SPSEL];
        end
        OFS_DLY0: dly_q[0] <= {pwdata[HI_LSB +: DLY_W], pwdata[LO_LSB +: DLY_W]};
        OFS_DLY1: dly_q[1] <= {pwdata[HI_LSB +: DLY_W], pwdata[LO_LSB +: DLY_W]};
        OFS_DLY2: dly_q[2] <= {pwdata[HI_LSB +: DLY_W], pwdata[LO_LSB +: DLY_W]};
        OFS_THR: begin
          hb_q[0].thr <= pwdata[LO_LSB +: CUR_W];
          hb_q[1].thr <= pwdata[HI_LSB +: CUR_W];
        end
        OFS_HYS: begin
          hb_q[0].hys <= pwdata[LO_LSB +: CUR_W];
          hb_q[1].hys <= pwdata[HI_LSB +: CUR_W];
        end
        OFS_CT_CFG: begin
          hb_q[0].asg <= pwdata[ASG1_LSB +: ASG_W];
          hb_q[1].asg <= pwdata[ASG2_LSB +: ASG_W];
          hb_q[0].latch <= pwdata[LATCH_LSB];
          hb_q[1].latch <= pwdata[LATCH_LSB + 1];
        end
        default: ;
      endcase
    end
  end

  cfg_frozen_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && pwrite && run_q && cfg_addr |=> pslverr
    ##1 ($stable(dly_q[0]) && $stable(hb_q[0].asg)))
    else $error("settings write accepted while running");

  // ==========================================================
  // setpoint reference
  logic [SP_W-1:0] ref_sp_q;
  logic use_final;

  // final setpoint only when a ramp is running without self tuning
  assign use_final = sp_sel_q & sp_ramp_en & ~self_tuning;
  assign alarm_ref_sp = ref_sp_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_sp_q <= '0;
    end else begin
      ref_sp_q <= use_final ? final_sp : ramp_sp;
    end
  end

  ref_select_a: assert property (@(posedge pclk) disable iff (!presetn)
    !sp_ramp_en || self_tuning |=> alarm_ref_sp == $past(ramp_sp))
    else $error("final setpoint used outside ramping");

  // ==========================================================
  // one-second tick
  logic [TW-1:0] pre_q;
  logic tick;

  assign tick = (pre_q == TW'(TICK_CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= '0;
    end else if (tick || sw_rst) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + 1'b1;
    end
  end

  // ==========================================================
  // alarm delays
  logic [N_ALM-1:0] alm_q;
  assign alarm_out = alm_q;

  for (genvar i = 0; i < N_ALM; i++) begin : g_alm
    logic [DLY_W:0] cnt_q;
    logic [DLY_W-1:0] dly;
    logic expire;

    // a changed condition uses the delay of the direction it moves to
    assign dly = alarm_raw[i] ? dly_q[i].on : dly_q[i].off;
    assign expire = (dly == '0) || (cnt_q > {1'b0, dly});

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        alm_q[i] <= 1'b0;
        cnt_q <= '0;
      end else if (sw_rst || typ_q[i] == '0) begin
        alm_q[i] <= 1'b0;
        cnt_q <= '0;
      end else if (alarm_raw[i] == alm_q[i]) begin
        cnt_q <= '0;
      end else if (expire) begin
        alm_q[i] <= alarm_raw[i];
        cnt_q <= '0;
      end else if (tick) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end

    on_delay_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(alm_q[i]) |-> $past(alarm_raw[i]) && ($past(cnt_q) > {1'b0, $past(dly_q[i].on)}
      || $past(dly_q[i].on) == '0)) else $error("alarm rose before on delay");
    off_delay_a: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(alm_q[i]) && !$past(sw_rst) && $past(typ_q[i]) != '0 |-> !$past(alarm_raw[i])
      && ($past(cnt_q) > {1'b0, $past(dly_q[i].off)} || $past(dly_q[i].off) == '0))
      else $error("alarm fell before off delay");
    restart_a: assert property (@(posedge pclk) disable iff (!presetn)
      alarm_raw[i] == alm_q[i] |=> cnt_q == '0) else $error("delay count not restarted");
    type_off_a: assert property (@(posedge pclk) disable iff (!presetn)
      typ_q[i] == '0 |=> !alm_q[i]) else $error("disabled alarm asserted");
  end

  // ==========================================================
  // heater burnout
  logic [N_CT-1:0] hb_out_q;
  // status only; nothing here feeds back into control
  assign heater_open_alarm = hb_out_q;

  for (genvar s = 0; s < N_CT; s++) begin : g_hb
    logic [OW-1:0] on_q;
    logic heat_on;
    logic eval;
    logic below;
    logic above;
    logic [CUR_W:0] clr_lvl;
    logic [1:0] idx;

    assign idx = hb_q[s].asg[1:0] - 2'h1;
    // cooling outputs are masked out
    assign heat_on = (hb_q[s].asg != '0) && ctrl_out_on[idx] && ctrl_out_heat[idx];
    assign eval = heat_on && (on_q > OW'(MIN_ON_CYCLES));
    assign clr_lvl = {1'b0, hb_q[s].thr} + {1'b0, hb_q[s].hys};
    assign below = cur_in[s] < hb_q[s].thr;
    assign above = {1'b0, cur_in[s]} > clr_lvl;

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        on_q <= '0;
      end else if (!heat_on) begin
        on_q <= '0;
      end else if (!eval) begin
        on_q <= on_q + 1'b1;
      end
    end

    // detection set wins over a release in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        hb_out_q[s] <= 1'b0;
      end else if (hb_q[s].thr == THR_FORCE_OFF) begin
        hb_out_q[s] <= 1'b0;
      end else if (hb_q[s].thr == THR_FORCE_ON) begin
        hb_out_q[s] <= 1'b1;
      end else if (eval && below) begin
        hb_out_q[s] <= 1'b1;
      end else if (sw_rst || err_rst) begin
        hb_out_q[s] <= 1'b0;
      end else if (hb_q[s].latch && hb_out_q[s]) begin
        hb_out_q[s] <= 1'b1;
      end else if (eval && above) begin
        hb_out_q[s] <= 1'b0;
      end
    end

    // monitor clipped to full scale
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        mon_q[s] <= '0;
      end else begin
        mon_q[s] <= (cur_in[s] > CUR_MAX) ? CUR_MAX : cur_in[s];
      end
    end

    force_off_a: assert property (@(posedge pclk) disable iff (!presetn)
      hb_q[s].thr == THR_FORCE_OFF |=> !hb_out_q[s]) else $error("forced off ignored");
    force_on_a: assert property (@(posedge pclk) disable iff (!presetn)
      hb_q[s].thr == THR_FORCE_ON |=> hb_out_q[s]) else $error("forced on ignored");
    short_on_a: assert property (@(posedge pclk) disable iff (!presetn)
      !eval && !sw_rst && !err_rst && hb_q[s].thr != THR_FORCE_OFF
      && hb_q[s].thr != THR_FORCE_ON |=> $stable(hb_out_q[s]))
      else $error("burnout changed without evaluation");
    latch_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      hb_q[s].latch && hb_out_q[s] && !sw_rst && !err_rst
      && hb_q[s].thr != THR_FORCE_OFF |=> hb_out_q[s]) else $error("latched alarm lost");
    // a cooling output must leave the alarm alone whatever the current
    cool_skip_a: assert property (@(posedge pclk) disable iff (!presetn)
      hb_q[s].asg != '0 && !ctrl_out_heat[idx] && !sw_rst && !err_rst
      && hb_q[s].thr != THR_FORCE_OFF && hb_q[s].thr != THR_FORCE_ON |=> $stable(hb_out_q[s]))
      else $error("cooling output evaluated");
  end

endmodule

// ==== src/adhb_pkg.sv ====
/*
  constants, register map and carrier types for the alarm delay and
  heater burnout block.
  assumes a 10 MHz pclk; currents and thresholds are in 0.1 A steps.
*/
package adhb_pkg;

  // ==========================================================
  // sizes
  localparam int N_ALM = 3;
  localparam int N_CT = 2;
  localparam int N_OUT = 4;
  localparam int DLY_W = 10;
  localparam int CUR_W = 11;
  localparam int TYP_W = 4;
  localparam int SP_W = 16;
  localparam int ASG_W = 3;

  // ==========================================================
  // timing
  localparam longint CLK_HZ = 10000000;
  localparam longint TICK_S = 1;
  localparam int TICK_CYC = int'(CLK_HZ * TICK_S);
  localparam longint MIN_ON_MS = 100;
  localparam int MIN_ON_CYC = int'(CLK_HZ * MIN_ON_MS / 1000);

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ALM_CFG = 8'h04;
  localparam logic [7:0] OFS_DLY0 = 8'h08;
  localparam logic [7:0] OFS_DLY1 = 8'h0c;
  localparam logic [7:0] OFS_DLY2 = 8'h10;
  localparam logic [7:0] OFS_THR = 8'h14;
  localparam logic [7:0] OFS_HYS = 8'h18;
  localparam logic [7:0] OFS_CT_CFG = 8'h1c;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_MON = 8'h24;

  // ==========================================================
  // field positions
  localparam int CTRL_RUN = 0;
  localparam int CTRL_SWRST = 1;
  localparam int CTRL_ERRRST = 2;
  localparam int ALM_SPSEL = 16;
  localparam int LO_LSB = 0;
  localparam int HI_LSB = 16;
  localparam int ASG1_LSB = 0;
  localparam int ASG2_LSB = 4;
  localparam int LATCH_LSB = 8;
  localparam int ST_HB_LSB = 4;

  // ==========================================================
  // values
  localparam logic [CUR_W-1:0] THR_FORCE_OFF = 11'h000;
  localparam logic [CUR_W-1:0] THR_FORCE_ON = 11'h3e8;
  localparam logic [CUR_W-1:0] CUR_MAX = 11'h44c;
  localparam logic [CUR_W-1:0] HYS_MAX = 11'h3e8;
  localparam logic [CUR_W-1:0] HYS_RST = 11'h001;
  localparam logic [ASG_W-1:0] ASG_MAX = 3'h4;
  localparam logic [ASG_W-1:0] ASG1_RST = 3'h1;
  localparam logic [ASG_W-1:0] ASG2_RST = 3'h2;
  localparam logic [DLY_W-1:0] DLY_MAX = 10'h3e7;

  typedef struct packed {
    logic [DLY_W-1:0] off;
    logic [DLY_W-1:0] on;
  } adhb_dly_t;

  typedef struct packed {
    logic [CUR_W-1:0] thr;
    logic [CUR_W-1:0] hys;
    logic [ASG_W-1:0] asg;
    logic latch;
  } adhb_hb_t;

endpackage

// ==== tb/adhb_ct_model.sv ====
/*
  behavioural current sensors on the heater supply line of output 1.
  assumes the bench sets the level each sensor sees while the line is energised.
*/
`timescale 1ns/1ns
module adhb_ct_model
  import adhb_pkg::*;
(
  // clock
  input wire logic pclk,
  // heater line
  input wire logic line_on,
  input wire logic [CUR_W-1:0] lvl_one,
  input wire logic [CUR_W-1:0] lvl_two,
  // sensor outputs
  output logic [CUR_W-1:0] current_sensor_one,
  output logic [CUR_W-1:0] current_sensor_two
);
  // ======================================
  // measurement
  // no current flows while the line is off, so a stale level never lingers
  always_ff @(posedge pclk) begin
    current_sensor_one <= line_on ? lvl_one : '0;
    current_sensor_two <= line_on ? lvl_two : '0;
  end
endmodule

// ==== tb/alarm_delay_heater_burnout_test.sv ====
/*
  self-checking bench for adhb_core over apb, with sensor model.
  assumes the hand-over timing: zero-wait apb, 10-cycle tick, 8-cycle min on.
*/
`timescale 1ns/1ns
module alarm_delay_heater_burnout_test
  import adhb_pkg::*;
;
  // ======================================
  // signals
  localparam int T = 10;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, op_running;
  logic sp_ramp_en = 1'b1, self_tuning = 1'b0;
  logic [N_ALM-1:0] alarm_raw = 3'h0;
  logic [N_ALM-1:0] alarm_out;
  logic [SP_W-1:0] ramp_sp = 16'h1234, final_sp = 16'h5678;
  logic [SP_W-1:0] alarm_ref_sp;
  logic [N_OUT-1:0] ctrl_out_on = 4'h0, ctrl_out_heat = 4'h1;
  logic [CUR_W-1:0] lvl_one = 11'h064, lvl_two = 11'h064;
  logic [CUR_W-1:0] cur_one, cur_two;
  logic [N_CT-1:0] heater_open_alarm;
  logic [4:0] obs;
  logic [7:0] rofs [8] = '{OFS_CTRL, OFS_ALM_CFG, OFS_DLY0, OFS_DLY1, OFS_DLY2, OFS_THR,
    OFS_HYS, OFS_CT_CFG};
  logic [31:0] rval [8] = '{0, 0, 0, 0, 0, 0, 32'h0001_0001, 32'h0000_0021};
  int errors = 0;
  int compares = 0;
  int i;
  assign obs = {heater_open_alarm, alarm_out};
  always #50 pclk = ~pclk;

  adhb_core #(.TICK_CYCLES(T), .MIN_ON_CYCLES(8)) uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .alarm_raw(alarm_raw),
    .alarm_out(alarm_out), .ramp_sp(ramp_sp), .final_sp(final_sp),
    .sp_ramp_en(sp_ramp_en), .self_tuning(self_tuning), .alarm_ref_sp(alarm_ref_sp),
    .ctrl_out_on(ctrl_out_on), .ctrl_out_heat(ctrl_out_heat),
    .current_sensor_one(cur_one), .current_sensor_two(cur_two),
    .heater_open_alarm(heater_open_alarm), .op_running(op_running));
  adhb_ct_model ct_model (.pclk(pclk), .line_on(ctrl_out_on[0]), .lvl_one(lvl_one),
    .lvl_two(lvl_two), .current_sensor_one(cur_one), .current_sensor_two(cur_two));

  // ======================================
  // tasks
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // read data is only compared when the access should be accepted
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [31:0] ed, input logic ee);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk({31'h0, pslverr}, {31'h0, ee});
    if (!w && !ee) chk(prdata, ed);
    chk({31'h0, pready}, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // hi below lo means obs[w] must not reach v within lo cycles
  task wait_bit(input int w, input logic v, input int lo, input int hi);
    int n;
    logic ok;
    n = 0;
    ok = 1'b0;
    while (n < ((hi < lo) ? lo : hi) && !ok) begin
      @(negedge pclk);
      n++;
      ok = (obs[w] === v);
    end
    chk({31'h0, (hi < lo) ? !ok : (ok && n >= lo)}, 32'h1);
  endtask

  task finish_test;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ======================================
  // watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    $display("watchdog expired");
    errors++;
    finish_test();
  end

  // ======================================
  // tests
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 8; i++) apb(1'b0, rofs[i], 0, rval[i], 1'b0);
    chk({16'h0, alarm_ref_sp}, 32'h1234);
    apb(1'b0, 8'h28, 0, 0, 1'b1);
    apb(1'b1, OFS_STATUS, 1, 0, 1'b0);
    apb(1'b1, OFS_HYS, 0, 0, 1'b1);
    apb(1'b1, OFS_THR, 32'h0000_03e9, 0, 1'b1);
    apb(1'b1, OFS_CT_CFG, 32'h0000_0005, 0, 1'b1);
    apb(1'b1, OFS_DLY0, 32'h0000_03e8, 0, 1'b1);
    apb(1'b1, OFS_CTRL, 1, 0, 1'b0);
    for (i = 1; i < 8; i++) apb(1'b1, rofs[i], 32'h0000_0011, 0, i != 5);
    apb(1'b0, OFS_DLY0, 0, 0, 1'b0);
    chk({31'h0, op_running}, 32'h1);
    apb(1'b1, OFS_CTRL, 0, 0, 1'b0);
    // alarm 1 waits 2 s on, 1 s off; alarm 2 immediate; alarm 3 disabled
    apb(1'b1, OFS_DLY0, 32'h0001_0002, 0, 1'b0);
    apb(1'b1, OFS_ALM_CFG, 32'h0000_0011, 0, 1'b0);
    @(posedge pclk);
    alarm_raw <= 3'b101;
    wait_bit(0, 1'b1, 15, 0);
    @(posedge pclk);
    alarm_raw <= 3'b100;
    repeat (3) @(posedge pclk);
    alarm_raw <= 3'b101;
    wait_bit(0, 1'b1, 2 * T, 3 * T + 3);
    apb(1'b0, OFS_STATUS, 0, 32'h1, 1'b0);
    @(posedge pclk);
    alarm_raw <= 3'b111;
    wait_bit(1, 1'b1, 1, 3);
    @(posedge pclk);
    alarm_raw <= 3'b110;
    wait_bit(0, 1'b0, 5, 0);
    @(posedge pclk);
    alarm_raw <= 3'b111;
    repeat (3) @(posedge pclk);
    alarm_raw <= 3'b110;
    wait_bit(0, 1'b0, T, 2 * T + 3);
    apb(1'b0, OFS_STATUS, 0, 32'h2, 1'b0);
    @(posedge pclk);
    alarm_raw <= 3'b111;
    wait_bit(0, 1'b1, 2 * T, 3 * T + 3);
    apb(1'b1, OFS_CTRL, 32'h2, 0, 1'b0);
    repeat (2) @(posedge pclk);
    chk({31'h0, alarm_out[0]}, 32'h0);
    wait_bit(0, 1'b1, 2 * T - 4, 3 * T + 3);
    apb(1'b1, OFS_ALM_CFG, 32'h0001_0011, 0, 1'b0);
    repeat (2) @(posedge pclk);
    chk({16'h0, alarm_ref_sp}, 32'h5678);
    self_tuning <= 1'b1;
    repeat (3) @(posedge pclk);
    chk({16'h0, alarm_ref_sp}, 32'h1234);
    self_tuning <= 1'b0;
    sp_ramp_en <= 1'b0;
    repeat (3) @(posedge pclk);
    chk({16'h0, alarm_ref_sp}, 32'h1234);
    // both sensors on output 1, threshold 5.0 A, hysteresis 1.0 A
    apb(1'b1, OFS_CT_CFG, 32'h0000_0011, 0, 1'b0);
    apb(1'b1, OFS_THR, 32'h0032_0032, 0, 1'b0);
    apb(1'b1, OFS_HYS, 32'h000a_000a, 0, 1'b0);
    @(posedge pclk);
    lvl_one <= 11'h014;
    lvl_two <= 11'h014;
    ctrl_out_on <= 4'h1;
    repeat (8) @(posedge pclk);
    ctrl_out_on <= 4'h0;
    wait_bit(3, 1'b1, 12, 0);
    @(posedge pclk);
    ctrl_out_heat <= 4'h0;
    ctrl_out_on <= 4'h1;
    wait_bit(3, 1'b1, 20, 0);
    @(posedge pclk);
    ctrl_out_heat <= 4'h1;
    wait_bit(3, 1'b1, 9, 14);
    wait_bit(4, 1'b1, 0, 2);
    chk({31'h0, op_running}, 32'h0);
    @(posedge pclk);
    lvl_one <= 11'h037;
    wait_bit(3, 1'b0, 15, 0);
    @(posedge pclk);
    lvl_one <= 11'h064;
    wait_bit(3, 1'b0, 1, 4);
    apb(1'b1, OFS_CT_CFG, 32'h0000_0111, 0, 1'b0);
    @(posedge pclk);
    lvl_one <= 11'h014;
    wait_bit(3, 1'b1, 1, 4);
    @(posedge pclk);
    lvl_one <= 11'h064;
    wait_bit(3, 1'b0, 15, 0);
    apb(1'b1, OFS_CTRL, 32'h4, 0, 1'b0);
    wait_bit(3, 1'b0, 1, 4);
    @(posedge pclk);
    lvl_one <= 11'h014;
    wait_bit(3, 1'b1, 1, 4);
    @(posedge pclk);
    lvl_one <= 11'h064;
    apb(1'b1, OFS_THR, 32'h0032_0000, 0, 1'b0);
    wait_bit(3, 1'b0, 1, 4);
    @(posedge pclk);
    lvl_one <= 11'h014;
    wait_bit(3, 1'b1, 15, 0);
    @(posedge pclk);
    lvl_one <= 11'h064;
    apb(1'b1, OFS_THR, 32'h0032_03e8, 0, 1'b0);
    wait_bit(3, 1'b1, 1, 4);
    @(posedge pclk);
    lvl_one <= 11'h7d0;
    repeat (3) @(posedge pclk);
    apb(1'b0, OFS_MON, 0, 32'h0014_044c, 1'b0);
    // sensor one unassigned, then moved to output 4 whose line carries nothing
    apb(1'b1, OFS_CT_CFG, 32'h0000_0010, 0, 1'b0);
    apb(1'b1, OFS_THR, 32'h0032_0000, 0, 1'b0);
    apb(1'b1, OFS_THR, 32'h0032_0032, 0, 1'b0);
    @(posedge pclk);
    lvl_one <= 11'h014;
    wait_bit(3, 1'b1, 15, 0);
    apb(1'b1, OFS_CT_CFG, 32'h0000_0014, 0, 1'b0);
    @(posedge pclk);
    ctrl_out_heat <= 4'h9;
    ctrl_out_on <= 4'h8;
    wait_bit(3, 1'b1, 9, 14);
    finish_test();
  end
endmodule
